// ==== bench/aec_rc_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// root complex side: counts correctable reports
// ************************************************************
module aec_rc_model
	import aec_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        cor_report,
	output var  logic [15:0] rpt_cnt
);
	// one message per reported cycle, so a stuck pulse shows as extra counts
	always_ff @(posedge clk) begin
		if (!resetn)
			rpt_cnt <= 16'h0000;
		else if (cor_report)
			rpt_cnt <= rpt_cnt + 16'h0001;
	end
endmodule : aec_rc_model

`default_nettype wire

// ==== bench/tb_advanced_error_correctable_regs.sv ====
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// bench for the correctable error register group
// ************************************************************
module tb_advanced_error_correctable_regs
	import aec_pkg::*;
;
	logic        clk, resetn, link_resetn, wr_stb, rd_stb;
	logic        unlock, urep, corr, gen, chkn, held;
	logic [11:0] addr;
	logic [31:0] wdata, rdata, hd0, hd1, ustat, pend;
	logic [5:0]  evt;
	logic [4:0]  ubit;
	logic [15:0] rc_cnt;
	int          failures, n_compared;

	aec_regs i_dut (.clk(clk), .resetn(resetn), .link_resetn(link_resetn),
		.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata(rdata), .reg_write_unlock(unlock), .rx_err_evt(evt[0]),
		.bad_pkt_evt(evt[1]), .bad_lnk_evt(evt[2]), .rply_roll_evt(evt[3]),
		.rply_to_evt(evt[4]), .adv_nf_evt(evt[5]), .uerr_report(urep),
		.uerr_bit(ubit), .uerr_hdr0(hd0), .uerr_hdr1(hd1),
		.uncor_status(ustat), .cor_report(corr), .cor_pending(pend),
		.crc_gen_enable(gen), .crc_check_enable(chkn), .log_held(held));

	aec_rc_model i_rc (.clk(clk), .resetn(resetn), .cor_report(corr),
		.rpt_cnt(rc_cnt));

	// ************************************************************
	// common tasks
	// ************************************************************
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// read data stand only in the cycle after the strobe
	task rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk) begin
			rd_stb <= 1'b1;
			addr   <= a;
		end
		@(posedge clk) rd_stb <= 1'b0;
		#1 chk($sformatf("reg %h", a), rdata, e);
	endtask : rd

	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk) begin
			wr_stb <= 1'b1;
			addr   <= a;
			wdata  <= d;
		end
		@(posedge clk) wr_stb <= 1'b0;
	endtask : wr

	task fund_reset;
		@(posedge clk) resetn <= 1'b0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
	endtask : fund_reset

	task conclude;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	// ************************************************************
	// scenarios
	// ************************************************************
	// defaults, unmapped places and the one-cycle read data
	task t_defaults;
		rd(AEC_OFF_CES, 32'h0000_0000);
		rd(AEC_OFF_CEM, 32'h0000_2000);
		rd(AEC_OFF_CTL, 32'h0000_00A0);
		rd(AEC_OFF_HL0, 32'h0000_0000);
		rd(AEC_OFF_HL1, 32'h0000_0000);
		wr(12'h124, 32'hFFFF_FFFF);
		rd(12'h124, 32'h0000_0000);
		@(posedge clk) #1 chk("rdata idle", rdata, 32'h0000_0000);
	endtask : t_defaults

	// every event sets its own flag; only unmasked ones reach the root complex
	task t_events;
		logic [15:0] c0;
		logic [31:0] b;
		for (int i = 0; i < AEC_NEVT; i++) begin
			c0 = rc_cnt;
			b = 32'h0000_0001 << AEC_EVT_POS[i];
			@(posedge clk) evt <= 6'h01 << i;
			@(posedge clk) evt <= 6'h00;
			rd(AEC_OFF_CES, b);
			chk("pending", pend, (i == 5) ? 32'h0000_0000 : b);
			chk("reports", {16'h0000, rc_cnt - c0}, (i == 5) ? 0 : 1);
			wr(AEC_OFF_CES, b);
			rd(AEC_OFF_CES, 32'h0000_0000);
		end
	endtask : t_events

	// full mask: flags still latch, nothing is reported
	task t_mask;
		logic [15:0] c0;
		c0 = rc_cnt;
		wr(AEC_OFF_CEM, 32'hFFFF_FFFF);
		rd(AEC_OFF_CEM, 32'h0000_31C1);
		@(posedge clk) evt <= 6'h3F;
		@(posedge clk) evt <= 6'h00;
		rd(AEC_OFF_CES, 32'h0000_31C1);
		chk("pending", pend, 32'h0000_0000);
		chk("reports", {16'h0000, rc_cnt}, {16'h0000, c0});
		// a rollover in the very cycle of the clearing write must survive it
		@(posedge clk) begin
			wr_stb <= 1'b1;
			addr   <= AEC_OFF_CES;
			wdata  <= 32'hFFFF_FFFF;
			evt    <= 6'h08;
		end
		@(posedge clk) begin
			wr_stb <= 1'b0;
			evt    <= 6'h00;
		end
		rd(AEC_OFF_CES, 32'h0000_0100);
		wr(AEC_OFF_CES, 32'h0000_0100);
		rd(AEC_OFF_CES, 32'h0000_0000);
		wr(AEC_OFF_CEM, 32'h0000_0000);
	endtask : t_mask

	// capability lock, crc enables and a link reset that spares sticky state
	task t_ctl;
		wr(AEC_OFF_CTL, 32'hFFFF_FFFF);
		rd(AEC_OFF_CTL, 32'h0000_01E0);
		chk("gen", {31'h0, gen}, 32'h1);
		chk("chk", {31'h0, chkn}, 32'h1);
		@(posedge clk) unlock <= 1'b1;
		wr(AEC_OFF_CTL, 32'h0000_0140);
		rd(AEC_OFF_CTL, 32'h0000_0140);
		// receiver and replay timeout flags must ride through the link reset
		@(posedge clk) evt <= 6'h11;
		@(posedge clk) begin
			evt         <= 6'h00;
			link_resetn <= 1'b0;
		end
		repeat (2) @(posedge clk);
		link_resetn <= 1'b1;
		rd(AEC_OFF_CTL, 32'h0000_01E0);
		rd(AEC_OFF_CES, 32'h0000_1001);
		chk("gen", {31'h0, gen}, 32'h1);
		wr(AEC_OFF_CES, 32'h0000_1001);
		wr(AEC_OFF_CTL, 32'h0000_00A0);
		unlock <= 1'b0;
		#1 chk("gen", {31'h0, gen}, 32'h0);
		chk("chk", {31'h0, chkn}, 32'h0);
	endtask : t_ctl

	// first report is held until its pointed flag is seen set then clear
	task t_cap;
		@(posedge clk) begin
			urep <= 1'b1;
			ubit <= 5'h04;
			hd0  <= 32'hA5A5_0001;
			hd1  <= 32'h5A5A_0002;
		end
		@(posedge clk) begin
			ubit <= 5'h09;
			hd0  <= 32'h1111_1111;
		end
		@(posedge clk) urep <= 1'b0;
		#1 chk("held", {31'h0, held}, 32'h1);
		rd(AEC_OFF_CTL, 32'h0000_00A4);
		wr(AEC_OFF_HL0, 32'hFFFF_FFFF);
		rd(AEC_OFF_HL0, 32'hA5A5_0001);
		rd(AEC_OFF_HL1, 32'h5A5A_0002);
		@(posedge clk) ustat <= 32'h0000_0010;
		@(posedge clk) ustat <= 32'h0000_0000;
		repeat (2) @(posedge clk);
		#1 chk("held", {31'h0, held}, 32'h0);
		@(posedge clk) urep <= 1'b1;
		@(posedge clk) urep <= 1'b0;
		rd(AEC_OFF_CTL, 32'h0000_00A9);
		rd(AEC_OFF_HL0, 32'h1111_1111);
		// a report while the pointed bit is still set must be ignored
		@(posedge clk) begin
			ustat <= 32'h0000_0200;
			urep  <= 1'b1;
			ubit  <= 5'h03;
			hd1   <= 32'h2222_2222;
		end
		@(posedge clk) urep <= 1'b0;
		rd(AEC_OFF_CTL, 32'h0000_00A9);
		rd(AEC_OFF_HL1, 32'h5A5A_0002);
	endtask : t_cap

	// ************************************************************
	// clock, stimulus and watchdog
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		resetn = 1'b0;
		link_resetn = 1'b1;
		{wr_stb, rd_stb, unlock, urep} = 4'h0;
		{addr, wdata, hd0, hd1, ustat} = '0;
		evt = 6'h00;
		ubit = 5'h00;
		failures = 0;
		n_compared = 0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		t_defaults();
		t_events();
		t_mask();
		t_ctl();
		t_cap();
		wr(AEC_OFF_CTL, 32'h0000_0140);
		rd(AEC_OFF_CTL, 32'h0000_01E9);
		fund_reset();
		t_defaults(); // sticky state returns to defaults only here
		conclude();
	end

	// the run needs well under a thousand cycles
	initial begin
		#50000;
		failures++;
		conclude();
	end
endmodule : tb_advanced_error_correctable_regs

`default_nettype wire

// ==== hw/aec_err_capture.sv ====
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// first uncorrectable error pointer and header capture
// ************************************************************
module aec_err_capture
	import aec_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        cap_req,
	input  wire logic [4:0]  cap_ptr,
	input  wire logic [31:0] cap_hdr0,
	input  wire logic [31:0] cap_hdr1,
	input  wire logic [31:0] uncor_status,
	output var  logic [4:0]  ptr_r,
	output var  logic [31:0] hdr0_r,
	output var  logic [31:0] hdr1_r,
	output var  logic        held_r
);

	logic seen_r;
	logic cur_set;
	logic release_now;
	logic load;

	// the status bit may rise a cycle after capture, so release only
	// once it has been seen set and then cleared by software
	assign cur_set     = uncor_status[ptr_r];
	assign release_now = held_r & seen_r & ~cur_set;
	assign load        = cap_req & (~held_r | release_now);

	// capture and hold are sticky: fundamental reset only
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ptr_r  <= AEC_PTR_RST;
			hdr0_r <= AEC_HL_RST;
			hdr1_r <= AEC_HL_RST;
			held_r <= 1'b0;
			seen_r <= 1'b0;
		end else if (load) begin
			ptr_r  <= cap_ptr;
			hdr0_r <= cap_hdr0;
			hdr1_r <= cap_hdr1;
			held_r <= 1'b1;
			seen_r <= 1'b0;
		end else if (release_now) begin
			held_r <= 1'b0;
			seen_r <= 1'b0;
		end else if (held_r && cur_set) begin
			seen_r <= 1'b1;
		end
	end

endmodule : aec_err_capture

`default_nettype wire

// ==== hw/aec_pkg.sv ====
// Behaviour
// - bit 0 of correctable status latches receiver errors, sticky, write one clears.
// - bit 6 latches corrupted packet detections, sticky, write one clears.
// - bit 7 latches corrupted link packet detections, sticky, write one clears.
// - bit 8 latches replay counter rollover, sticky, write one clears.
// - bit 12 latches replay timer expiry, sticky, write one clears.
// - bit 13 latches advisory non-fatal errors, sticky, write one clears.
// - a set mask bit stops that event being reported to the root complex.
// - advisory non-fatal mask resets to one, all other mask bits to zero.
// - control bits 4:0 hold the sticky read-only first error pointer.
// - control bit 5, crc generation capable, resets to one, writable only unlocked.
// - sticky control bit 6 enables crc generation on transmit, resets to zero.
// - control bit 7, crc check capable, resets to one, writable only unlocked.
// - sticky control bit 8 enables crc checking on receive, resets to zero.
// - header log word 0 captures first header doubleword of first uncorrectable error.
// - header log word 1 captures second header doubleword of first uncorrectable error.
`default_nettype none

package aec_pkg;

	// ************************************************************
	// register offsets (byte addresses)
	// ************************************************************
	localparam int          AEC_ADDR_W       = 12;
	localparam logic [11:0] AEC_OFF_CES      = 12'h110;
	localparam logic [11:0] AEC_OFF_CEM      = 12'h114;
	localparam logic [11:0] AEC_OFF_CTL      = 12'h118;
	localparam logic [11:0] AEC_OFF_HL0      = 12'h11C;
	localparam logic [11:0] AEC_OFF_HL1      = 12'h120;

	// ************************************************************
	// correctable event positions and masks
	// ************************************************************
	localparam int          AEC_NEVT         = 6;
	localparam int          AEC_POS_RCV      = 0;
	localparam int          AEC_POS_BADPKT   = 6;
	localparam int          AEC_POS_BADLNK   = 7;
	localparam int          AEC_POS_ROLL     = 8;
	localparam int          AEC_POS_REPLAY_TIMEOUT_FLAG   = 12;
	localparam int          AEC_POS_ADVNF    = 13;
	localparam int          AEC_EVT_POS [AEC_NEVT] = '{0, 6, 7, 8, 12, 13};
	localparam logic [31:0] AEC_CES_IMPL     = 32'h0000_31C1;
	localparam logic [31:0] AEC_CES_RST      = 32'h0000_0000;
	localparam logic [31:0] AEC_CEM_RST      = 32'h0000_2000;

	// ************************************************************
	// control register fields
	// ************************************************************
	localparam int          AEC_CTL_PTR_LSB  = 0;
	localparam int          AEC_CTL_PTR_W    = 5;
	localparam int          AEC_CTL_GENCAP   = 5;
	localparam int          AEC_CTL_GENEN    = 6;
	localparam int          AEC_CTL_CHKCAP   = 7;
	localparam int          AEC_CTL_CHKEN    = 8;
	localparam logic        AEC_CAP_RST      = 1'b1;
	localparam logic        AEC_EN_RST       = 1'b0;
	localparam logic [4:0]  AEC_PTR_RST      = 5'h00;
	localparam logic [31:0] AEC_HL_RST       = 32'h0000_0000;

endpackage : aec_pkg

`default_nettype wire

// ==== hw/aec_regs.sv ====
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// correctable error register group of one port
// ************************************************************
module aec_regs
	import aec_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        link_resetn,
	input  wire logic [11:0] addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output var  logic [31:0] rdata,
	input  wire logic        reg_write_unlock,
	input  wire logic        rx_err_evt,
	input  wire logic        bad_pkt_evt,
	input  wire logic        bad_lnk_evt,
	input  wire logic        rply_roll_evt,
	input  wire logic        rply_to_evt,
	input  wire logic        adv_nf_evt,
	input  wire logic        uerr_report,
	input  wire logic [4:0]  uerr_bit,
	input  wire logic [31:0] uerr_hdr0,
	input  wire logic [31:0] uerr_hdr1,
	input  wire logic [31:0] uncor_status,
	output var  logic        cor_report,
	output logic [31:0]      cor_pending,
	output var  logic        crc_gen_enable,
	output var  logic        crc_check_enable,
	output var  logic        log_held
);

	// ************************************************************
	// address decode
	// ************************************************************
	logic sel_ces;
	logic sel_cem;
	logic sel_ctl;
	logic sel_hl0;
	logic sel_hl1;
	logic wr_ces;
	logic wr_cem;
	logic wr_ctl;

	// decode is exact on the full byte address; anything else reads zero
	assign sel_ces = (addr == AEC_OFF_CES);
	assign sel_cem = (addr == AEC_OFF_CEM);
	assign sel_ctl = (addr == AEC_OFF_CTL);
	assign sel_hl0 = (addr == AEC_OFF_HL0);
	assign sel_hl1 = (addr == AEC_OFF_HL1);
	assign wr_ces  = wr_stb & sel_ces;
	assign wr_cem  = wr_stb & sel_cem;
	assign wr_ctl  = wr_stb & sel_ctl;

	// ************************************************************
	// correctable status flags
	// ************************************************************
	logic [AEC_NEVT-1:0] evt_vec;
	logic [AEC_NEVT-1:0] flag_vec;
	logic [AEC_NEVT-1:0] clr_vec;

	// event order follows the bit order of the status register
	assign evt_vec = {adv_nf_evt, rply_to_evt, rply_roll_evt,
			  bad_lnk_evt, bad_pkt_evt, rx_err_evt};

	// each flag sits at its own bit and is cleared by writing one there
	genvar gi;
	generate
		for (gi = 0; gi < AEC_NEVT; gi++) begin : g_flag
			assign clr_vec[gi] = wr_ces & wdata[AEC_EVT_POS[gi]];
			aec_w1c_flag u_flag (
				.clk    (clk),
				.resetn (resetn),
				.set    (evt_vec[gi]),
				.clr    (clr_vec[gi]),
				.q      (flag_vec[gi])
			);
		end
	endgenerate

	logic [31:0] ces_word;

	// scatter flags to their documented positions, rest stays zero
	always_comb begin
		ces_word = AEC_CES_RST;
		for (int i = 0; i < AEC_NEVT; i++) begin
			ces_word[AEC_EVT_POS[i]] = flag_vec[i];
		end
	end

	// ************************************************************
	// correctable mask
	// ************************************************************
	logic [31:0] cem_r;
	logic [31:0] cem_nxt;

	// only implemented bits take write data
	assign cem_nxt = wdata & AEC_CES_IMPL;

	// sticky: a link reset leaves the mask untouched
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cem_r <= AEC_CEM_RST;
		end else if (wr_cem) begin
			cem_r <= cem_nxt;
		end
	end

	// ************************************************************
	// reporting towards the root complex
	// ************************************************************
	logic [31:0] evt_word;
	logic [31:0] unmasked;

	// spread the raw event inputs to their status bit positions
	always_comb begin
		evt_word = 32'h0000_0000;
		for (int i = 0; i < AEC_NEVT; i++) begin
			evt_word[AEC_EVT_POS[i]] = evt_vec[i];
		end
	end

	// a masked event still sets its status flag, it is only not reported
	assign unmasked    = evt_word & ~cem_r;
	assign cor_pending = ces_word & ~cem_r;

	// one-cycle report pulse per cycle with any unmasked event
	always_ff @(posedge clk) begin
		if (!resetn || !link_resetn) begin
			cor_report <= 1'b0;
		end else begin
			cor_report <= |unmasked;
		end
	end

	// ************************************************************
	// control register
	// ************************************************************
	logic gencap_r;
	logic chkcap_r;
	logic ctl_lock_wr;

	// capability bits take write data only while the write lock is open
	assign ctl_lock_wr = wr_ctl & reg_write_unlock;

	// capability bits are not sticky, so link resets restore them too
	always_ff @(posedge clk) begin
		if (!resetn || !link_resetn) begin
			gencap_r <= AEC_CAP_RST;
			chkcap_r <= AEC_CAP_RST;
		end else if (ctl_lock_wr) begin
			gencap_r <= wdata[AEC_CTL_GENCAP];
			chkcap_r <= wdata[AEC_CTL_CHKCAP];
		end
	end

	// enables are sticky and drive the crc datapath directly
	always_ff @(posedge clk) begin
		if (!resetn) begin
			crc_gen_enable   <= AEC_EN_RST;
			crc_check_enable <= AEC_EN_RST;
		end else if (wr_ctl) begin
			crc_gen_enable   <= wdata[AEC_CTL_GENEN];
			crc_check_enable <= wdata[AEC_CTL_CHKEN];
		end
	end

	// ************************************************************
	// first error pointer and header log
	// ************************************************************
	logic [4:0]  ptr_q;
	logic [31:0] hl0_q;
	logic [31:0] hl1_q;

	// held contents ignore later errors until the pointed flag clears
	aec_err_capture u_cap (
		.clk          (clk),
		.resetn       (resetn),
		.cap_req      (uerr_report),
		.cap_ptr      (uerr_bit),
		.cap_hdr0     (uerr_hdr0),
		.cap_hdr1     (uerr_hdr1),
		.uncor_status (uncor_status),
		.ptr_r        (ptr_q),
		.hdr0_r       (hl0_q),
		.hdr1_r       (hl1_q),
		.held_r       (log_held)
	);

	logic [31:0] ctl_word;

	// read-only pointer in 4:0, reserved 31:9 tied low
	always_comb begin
		ctl_word = 32'h0000_0000;
		ctl_word[AEC_CTL_PTR_LSB +: AEC_CTL_PTR_W] = ptr_q;
		ctl_word[AEC_CTL_GENCAP] = gencap_r;
		ctl_word[AEC_CTL_GENEN]  = crc_gen_enable;
		ctl_word[AEC_CTL_CHKCAP] = chkcap_r;
		ctl_word[AEC_CTL_CHKEN]  = crc_check_enable;
	end

	// ************************************************************
	// read path
	// ************************************************************
	logic [31:0] rd_mux;

	// unmapped addresses answer zero rather than stalling the master
	assign rd_mux = sel_ces ? ces_word :
			sel_cem ? cem_r :
			sel_ctl ? ctl_word :
			sel_hl0 ? hl0_q :
			sel_hl1 ? hl1_q :
			32'h0000_0000;

	// data stand only in the cycle after the read strobe
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata <= 32'h0000_0000;
		end else if (rd_stb) begin
			rdata <= rd_mux;
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// status flags: each event sets its flag, only a written one clears it
	a_rcv_flag_set: assert property (rx_err_evt |=> ces_word[AEC_POS_RCV])
		else $error("receiver error flag not set");

	a_badpkt_sticky: assert property (
		ces_word[AEC_POS_BADPKT] && !clr_vec[1] |=> ces_word[AEC_POS_BADPKT])
		else $error("bad packet flag lost without clear");

	a_badlnk_clear: assert property (
		wr_ces && wdata[AEC_POS_BADLNK] && !bad_lnk_evt
		|=> !ces_word[AEC_POS_BADLNK])
		else $error("bad link packet flag not cleared");

	a_roll_set_wins: assert property (
		rply_roll_evt && wr_ces && wdata[AEC_POS_ROLL]
		|=> ces_word[AEC_POS_ROLL])
		else $error("rollover event lost to clear");

	// a link reset must not touch a flag that nobody clears
	a_replay_timeout_flag_hold: assert property (
		ces_word[AEC_POS_REPLAY_TIMEOUT_FLAG] && !link_resetn && !clr_vec[4]
		|=> ces_word[AEC_POS_REPLAY_TIMEOUT_FLAG])
		else $error("replay timeout flag lost on link reset");

	a_advnf_read: assert property (
		ces_word[AEC_POS_ADVNF] && rd_stb && sel_ces
		|=> rdata[AEC_POS_ADVNF])
		else $error("advisory flag not readable");

	a_evt_flags_set: assert property (
		|evt_word
		|=> (ces_word & $past(evt_word)) == $past(evt_word))
		else $error("event did not set its flag");

	a_flags_sticky: assert property (
		!link_resetn && !wr_ces
		|=> (ces_word & $past(ces_word)) == $past(ces_word))
		else $error("status flag lost on link reset");

	// reporting follows the mask, the flags do not
	a_mask_blocks: assert property (
		cem_r[AEC_POS_ADVNF] && adv_nf_evt && !(|(evt_word & ~cem_r))
		|=> !cor_report)
		else $error("masked event reported");

	a_unmasked_rpt: assert property (
		rx_err_evt && !cem_r[AEC_POS_RCV] && link_resetn
		|=> cor_report)
		else $error("unmasked event not reported");

	a_mask_reset: assert property ($rose(resetn) |-> cem_r == AEC_CEM_RST)
		else $error("mask reset value wrong");

	a_mask_resv: assert property ((cem_r & ~AEC_CES_IMPL) == 32'h0000_0000)
		else $error("reserved mask bits set");

	// control: capabilities follow the lock, enables survive link resets
	a_cap_locked: assert property (
		wr_ctl && !reg_write_unlock && link_resetn
		|=> $stable(gencap_r) && $stable(chkcap_r))
		else $error("capability bits written while locked");

	a_cap_restore: assert property (
		!link_resetn |=> ctl_word[AEC_CTL_GENCAP] && ctl_word[AEC_CTL_CHKCAP])
		else $error("capability bits not restored");

	a_en_write: assert property (
		wr_ctl |=> crc_gen_enable == $past(wdata[AEC_CTL_GENEN])
		 && crc_check_enable == $past(wdata[AEC_CTL_CHKEN]))
		else $error("crc enables do not follow write");

	a_en_sticky: assert property (
		!link_resetn && !wr_ctl
		|=> crc_gen_enable == $past(crc_gen_enable)
		 && crc_check_enable == $past(crc_check_enable))
		else $error("crc enables lost on link reset");

	// pointer and header log: first report captured, later ones ignored
	a_log_hold: assert property (
		log_held && uerr_report && uncor_status[ptr_q]
		|=> $stable(hl0_q) && $stable(hl1_q) && $stable(ptr_q))
		else $error("header log overwritten while held");

	a_first_cap: assert property (
		!log_held && uerr_report
		|=> ptr_q == $past(uerr_bit) && hl0_q == $past(uerr_hdr0)
		 && hl1_q == $past(uerr_hdr1))
		else $error("first error not captured");

	a_ptr_readonly: assert property (
		wr_stb && !uerr_report
		|=> $stable(ptr_q) && $stable(hl0_q) && $stable(hl1_q))
		else $error("pointer or header log changed by a write");

	a_resv_zero: assert property (
		rd_stb && sel_ctl |=> rdata[31:9] == 23'h000000)
		else $error("reserved control bits read nonzero");

	a_resv_status: assert property (
		rd_stb && sel_ces |=> (rdata & ~AEC_CES_IMPL) == 32'h0000_0000)
		else $error("reserved status bits read nonzero");

	c_evt_report:  cover property (rx_err_evt ##1 cor_report);
	c_w1c_clear:   cover property (ces_word[AEC_POS_BADPKT] ##1 wr_ces ##1
				       !ces_word[AEC_POS_BADPKT]);
	c_log_release: cover property (log_held ##[1:20] !log_held);
	c_lock_write:  cover property (ctl_lock_wr && !wdata[AEC_CTL_GENCAP]);
	c_link_reset:  cover property (!link_resetn ##1 link_resetn);

endmodule : aec_regs

`default_nettype wire

// ==== hw/aec_w1c_flag.sv ====
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// one sticky write-one-to-clear status flag
// ************************************************************
module aec_w1c_flag
	import aec_pkg::*;
(
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic set,
	input  wire logic clr,
	output var  logic q
);

	logic q_nxt;

	// set wins over a clear in the same cycle so no event is lost
	assign q_nxt = set | (q & ~clr);

	// only the fundamental reset reaches this flop, link resets do not
	always_ff @(posedge clk) begin
		if (!resetn) begin
			q <= 1'b0;
		end else begin
			q <= q_nxt;
		end
	end

endmodule : aec_w1c_flag

`default_nettype wire
